/* core/chan_sync_pkg.sv */
// What this block does
// RQ1 - host sleeps channel, loads setup, start hold-off of one, then clears sleep
// RQ2 - a channel processes data only while its sleep bit is low
// RQ3 - reset puts all four channels to sleep
// RQ4 - start and sync bits written together start the start countdowns
// RQ5 - start countdown reaching one clears the channel sleep bit
// RQ6 - soft start: ready rise to processing is hold-off plus six cycles
// RQ7 - host loads sync hold-offs from one up to two to sixteen minus one
// RQ8 - four sync pins, each channel selects any one of them
// RQ9 - host sets start-on-pin and pin enable after loading the hold-off
// RQ10 - enabled sync pin sampled high starts the start countdown
// RQ11 - pin start: pin rise to processing is hold-off plus three cycles
// RQ12 - frequency hold-off of zero makes a frequency write take effect at once
// RQ13 - hop and sync bits written together start the frequency countdowns
// RQ14 - frequency countdown reaching one moves the pending frequency to the oscillator
// RQ15 - soft hop: ready rise to new frequency is hold-off plus seven cycles
// RQ16 - hop-on-pin and pin enable set, pin sampled high starts frequency countdown
// RQ17 - pin hop: pin rise to new frequency is hold-off plus five cycles
// RQ18 - host programs frequency hold-off first, then the new frequency
// RQ19 - with a non-zero frequency hold-off, a written frequency waits in a shadow register until released
// RQ20 - each channel owns its own start and frequency hold-off counters
package chan_sync_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int NUM_PINS = 4;
    localparam int CNT_W = 16;
    localparam int FREQ_W = 32;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // external address registers
    // ------------------------------------------------------------
    localparam logic [2:0] EXT_SLEEP = 3'h3;
    localparam logic [2:0] EXT_PIN_HOP = 3'h4;
    localparam logic [2:0] EXT_SOFT_START = 3'h5;

    // ------------------------------------------------------------
    // channel registers
    // ------------------------------------------------------------
    localparam logic [7:0] CH_START_HOLDOFF = 8'h83;
    localparam logic [7:0] CH_FREQ_HOLDOFF = 8'h84;
    localparam logic [7:0] CH_TUNE_FREQ = 8'h85;
    localparam logic [7:0] CH_PIN_SEL = 8'h86;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SYNC_LSB = 0;
    localparam int START_BIT = 4;
    localparam int HOP_BIT = 4;
    localparam int START_ON_PIN_BIT = 5;
    localparam int HOP_ON_PIN_BIT = 6;
    localparam int PIN_EN_LSB = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] SLEEP_RST = 4'hf;
    localparam logic [15:0] HOLDOFF_RST = 16'h0000;
    localparam logic [31:0] FREQ_RST = 32'h00000000;
    localparam logic [31:0] EXT_RST = 32'h00000000;
    localparam logic [1:0] PIN_SEL_RST = 2'h0;

    // ------------------------------------------------------------
    // trigger latencies in master clocks
    // ------------------------------------------------------------
    localparam int SOFT_START_LAT = 6;
    localparam int PIN_START_LAT = 3;
    localparam int SOFT_HOP_LAT = 7;
    localparam int PIN_HOP_LAT = 5;

    // host access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic ext;
        logic [1:0] chan;
        logic [7:0] addr;
        logic [31:0] data;
    } reg_req_t;

endpackage

/* core/channel_start_hop_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_start_hop_sync #(
    parameter int NUM_CH = chan_sync_pkg::NUM_CH,
    parameter int FREQ_W = chan_sync_pkg::FREQ_W
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire chan_sync_pkg::reg_req_t req_in,
    input wire logic [chan_sync_pkg::NUM_PINS-1:0] sync_pin_in,
    output logic ready_out,
    output logic [chan_sync_pkg::DATA_W-1:0] rd_data_out,
    output logic [NUM_CH-1:0] chan_active_out,
    output logic [NUM_CH*FREQ_W-1:0] osc_freq_out
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (NUM_CH < 1 || NUM_CH > 4)
    begin : g_bad_ch
        $error("channel count must be 1 to 4");
    end
    if (FREQ_W < 1 || FREQ_W > chan_sync_pkg::DATA_W)
    begin : g_bad_fw
        $error("frequency width must be 1 to 32");
    end

    localparam int SSL = chan_sync_pkg::SOFT_START_LAT;
    localparam int PSL = chan_sync_pkg::PIN_START_LAT;
    localparam int SHL = chan_sync_pkg::SOFT_HOP_LAT;
    localparam int PHL = chan_sync_pkg::PIN_HOP_LAT;
    localparam int CW = chan_sync_pkg::CNT_W;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic ext_wr;
    logic ext3_wr;
    logic ext4_wr;
    logic ext5_wr;
    logic [chan_sync_pkg::DATA_W-1:0] ext4_q;
    logic [chan_sync_pkg::DATA_W-1:0] ext5_q;
    logic [NUM_CH-1:0] fire_start;
    logic [NUM_CH-1:0] awake_q;
    logic [CW-1:0] start_hold_rd [NUM_CH];
    logic [CW-1:0] freq_hold_rd [NUM_CH];
    logic [FREQ_W-1:0] shadow_rd [NUM_CH];
    logic [1:0] pin_sel_rd [NUM_CH];
    logic [chan_sync_pkg::DATA_W-1:0] rd_d;

    assign ext_wr = req_in.wr && req_in.ext;
    assign ext3_wr = ext_wr && (req_in.addr[2:0] == chan_sync_pkg::EXT_SLEEP);
    assign ext4_wr = ext_wr && (req_in.addr[2:0] == chan_sync_pkg::EXT_PIN_HOP);
    assign ext5_wr = ext_wr && (req_in.addr[2:0] == chan_sync_pkg::EXT_SOFT_START);

    // ext 4 and ext 5 storage
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ext4_q <= chan_sync_pkg::EXT_RST;
            ext5_q <= chan_sync_pkg::EXT_RST;
        end
        else
        begin
            if (ext4_wr)
                ext4_q <= req_in.data;
            if (ext5_wr)
                ext5_q <= req_in.data;
        end
    end

    // ready pulse on every accepted access, read data registered
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ready_out <= 1'b0;
            rd_data_out <= '0;
        end
        else
        begin
            ready_out <= req_in.wr || req_in.rd;
            if (req_in.rd)
                rd_data_out <= rd_d;
        end
    end

    // read mux, unmapped reads as zero
    always_comb
    begin
        rd_d = '0;
        if (req_in.ext)
        begin
            case (req_in.addr[2:0])
                chan_sync_pkg::EXT_SLEEP: rd_d[NUM_CH-1:0] = ~awake_q;
                chan_sync_pkg::EXT_PIN_HOP: rd_d = ext4_q;
                chan_sync_pkg::EXT_SOFT_START: rd_d = ext5_q;
                default: rd_d = '0;
            endcase
        end
        else if (int'(req_in.chan) < NUM_CH)
        begin
            case (req_in.addr)
                chan_sync_pkg::CH_START_HOLDOFF: rd_d[CW-1:0] = start_hold_rd[req_in.chan];
                chan_sync_pkg::CH_FREQ_HOLDOFF: rd_d[CW-1:0] = freq_hold_rd[req_in.chan];
                chan_sync_pkg::CH_TUNE_FREQ: rd_d[FREQ_W-1:0] = shadow_rd[req_in.chan];
                chan_sync_pkg::CH_PIN_SEL: rd_d[1:0] = pin_sel_rd[req_in.chan];
                default: rd_d = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sleep control
    // ------------------------------------------------------------
    // countdown release wins over a same-cycle sleep write
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            awake_q <= ~chan_sync_pkg::SLEEP_RST[NUM_CH-1:0]; // RQ3
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (fire_start[i])
                    awake_q[i] <= 1'b1; // RQ5
                else if (ext3_wr)
                    awake_q[i] <= ~req_in.data[i]; // RQ2
            end
        end
    end
    assign chan_active_out = awake_q; // RQ2

    // ------------------------------------------------------------
    // per-channel hold-off logic
    // ------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        logic ch_wr;
        logic [CW-1:0] start_hold_q;
        logic [CW-1:0] freq_hold_q;
        logic [FREQ_W-1:0] shadow_q;
        logic [FREQ_W-1:0] osc_q;
        logic [1:0] pin_sel_q;
        logic start_arm_q;
        logic hop_arm_q;
        logic pin_hit;
        logic pin_start;
        logic pin_hop;
        logic soft_start;
        logic soft_hop;
        logic [SSL-1:0] ss_pipe_q;
        logic [PSL-1:0] ps_pipe_q;
        logic [SHL-1:0] sh_pipe_q;
        logic [PHL-1:0] ph_pipe_q;
        logic [CW-1:0] scnt_q;
        logic srun_q;
        logic [CW-1:0] fcnt_q;
        logic frun_q;
        logic fire_hop;

        assign ch_wr = req_in.wr && !req_in.ext && (int'(req_in.chan) == c);
        assign start_hold_rd[c] = start_hold_q;
        assign freq_hold_rd[c] = freq_hold_q;
        assign shadow_rd[c] = shadow_q;
        assign pin_sel_rd[c] = pin_sel_q;

        // channel register writes
        always_ff @(posedge clock_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
            begin
                start_hold_q <= chan_sync_pkg::HOLDOFF_RST;
                freq_hold_q <= chan_sync_pkg::HOLDOFF_RST;
                shadow_q <= chan_sync_pkg::FREQ_RST[FREQ_W-1:0];
                pin_sel_q <= chan_sync_pkg::PIN_SEL_RST;
            end
            else if (ch_wr)
            begin
                case (req_in.addr)
                    chan_sync_pkg::CH_START_HOLDOFF: start_hold_q <= req_in.data[CW-1:0];
                    chan_sync_pkg::CH_FREQ_HOLDOFF: freq_hold_q <= req_in.data[CW-1:0];
                    chan_sync_pkg::CH_TUNE_FREQ: shadow_q <= req_in.data[FREQ_W-1:0]; // RQ19
                    chan_sync_pkg::CH_PIN_SEL: pin_sel_q <= req_in.data[1:0]; // RQ8
                    default: ;
                endcase
            end
        end

        // trigger sources
        assign soft_start = ext5_wr && req_in.data[chan_sync_pkg::START_BIT]
            && req_in.data[chan_sync_pkg::SYNC_LSB + c]; // RQ4
        assign soft_hop = ext4_wr && req_in.data[chan_sync_pkg::HOP_BIT]
            && req_in.data[chan_sync_pkg::SYNC_LSB + c]; // RQ13
        assign pin_hit = sync_pin_in[pin_sel_q]
            && ext4_q[chan_sync_pkg::PIN_EN_LSB + int'(pin_sel_q)]; // RQ8
        assign pin_start = start_arm_q && pin_hit; // RQ10
        assign pin_hop = hop_arm_q && pin_hit; // RQ16

        // pin arming, one trigger per arming
        always_ff @(posedge clock_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
            begin
                start_arm_q <= 1'b0;
                hop_arm_q <= 1'b0;
            end
            else if (ext4_wr)
            begin
                start_arm_q <= req_in.data[chan_sync_pkg::START_ON_PIN_BIT]
                    && req_in.data[chan_sync_pkg::SYNC_LSB + c];
                hop_arm_q <= req_in.data[chan_sync_pkg::HOP_ON_PIN_BIT]
                    && req_in.data[chan_sync_pkg::SYNC_LSB + c]; // RQ16
            end
            else
            begin
                if (pin_start)
                    start_arm_q <= 1'b0;
                if (pin_hop)
                    hop_arm_q <= 1'b0;
            end
        end

        // trigger delay lines set the fixed latency
        always_ff @(posedge clock_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
            begin
                ss_pipe_q <= '0;
                ps_pipe_q <= '0;
                sh_pipe_q <= '0;
                ph_pipe_q <= '0;
            end
            else
            begin
                ss_pipe_q <= {ss_pipe_q[SSL-2:0], soft_start}; // RQ6
                ps_pipe_q <= {ps_pipe_q[PSL-2:0], pin_start}; // RQ11
                sh_pipe_q <= {sh_pipe_q[SHL-2:0], soft_hop}; // RQ15
                ph_pipe_q <= {ph_pipe_q[PHL-2:0], pin_hop}; // RQ17
            end
        end

        // start countdown, fires when it reaches one
        assign fire_start[c] = srun_q && (scnt_q == CW'(1)); // RQ5
        always_ff @(posedge clock_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
            begin
                scnt_q <= '0;
                srun_q <= 1'b0;
            end
            else if (ss_pipe_q[SSL-1] || ps_pipe_q[PSL-1])
            begin
                scnt_q <= start_hold_q; // RQ20
                srun_q <= (start_hold_q != '0);
            end
            else if (srun_q)
            begin
                scnt_q <= scnt_q - CW'(1); // RQ4
                srun_q <= !fire_start[c];
            end
        end

        // frequency countdown, fires when it reaches one
        assign fire_hop = frun_q && (fcnt_q == CW'(1)); // RQ14
        always_ff @(posedge clock_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
            begin
                fcnt_q <= '0;
                frun_q <= 1'b0;
            end
            else if (sh_pipe_q[SHL-1] || ph_pipe_q[PHL-1])
            begin
                fcnt_q <= freq_hold_q; // RQ20
                frun_q <= (freq_hold_q != '0);
            end
            else if (frun_q)
            begin
                fcnt_q <= fcnt_q - CW'(1); // RQ13
                frun_q <= !fire_hop;
            end
        end

        // oscillator frequency: direct when hold-off is zero, else on release
        always_ff @(posedge clock_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
                osc_q <= chan_sync_pkg::FREQ_RST[FREQ_W-1:0];
            else if (ch_wr && req_in.addr == chan_sync_pkg::CH_TUNE_FREQ
                && freq_hold_q == '0)
                osc_q <= req_in.data[FREQ_W-1:0]; // RQ12
            else if (fire_hop)
                osc_q <= shadow_q; // RQ14
        end
        assign osc_freq_out[c*FREQ_W +: FREQ_W] = osc_q;
    end

endmodule
`default_nettype wire

/* test/channel_start_hop_sync_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_start_hop_sync_asserts #(
    parameter int NUM_CH = 4,
    parameter int FREQ_W = 32
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire chan_sync_pkg::reg_req_t req_in,
    input wire logic [chan_sync_pkg::NUM_PINS-1:0] sync_pin_in,
    input wire logic ready_out,
    input wire logic [chan_sync_pkg::DATA_W-1:0] rd_data_out,
    input wire logic [NUM_CH-1:0] chan_active_out,
    input wire logic [NUM_CH*FREQ_W-1:0] osc_freq_out
);
    // ------------------------------------------------------------
    // channel 0 register shadows
    // ------------------------------------------------------------
    logic [15:0] start_hold_q;
    logic [15:0] freq_hold_q;
    logic [31:0] freq_next_q;
    logic ch0_wr;
    logic ext_wr;
    logic [FREQ_W-1:0] osc0;

    // decoded host writes
    assign ch0_wr = req_in.wr && !req_in.ext && req_in.chan == 2'h0;
    assign ext_wr = req_in.wr && req_in.ext;
    assign osc0 = osc_freq_out[FREQ_W-1:0];

    // hold-offs and pending frequency of channel 0
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            start_hold_q <= 16'h0000;
            freq_hold_q <= 16'h0000;
            freq_next_q <= 32'h00000000;
        end
        else if (ch0_wr)
        begin
            if (req_in.addr == chan_sync_pkg::CH_START_HOLDOFF)
                start_hold_q <= req_in.data[15:0];
            if (req_in.addr == chan_sync_pkg::CH_FREQ_HOLDOFF)
                freq_hold_q <= req_in.data[15:0];
            if (req_in.addr == chan_sync_pkg::CH_TUNE_FREQ)
                freq_next_q <= req_in.data;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    a_ready_after_req: assert property ((req_in.wr || req_in.rd) |=> ready_out)
        else $error("ready missing after access");
    a_ready_when_idle: assert property (!(req_in.wr || req_in.rd) |=> !ready_out)
        else $error("ready without access");
    a_reset_all_asleep: assert property (disable iff (1'h0)
        $rose(rst_n_in) |-> chan_active_out == '0 && osc_freq_out == '0)
        else $error("channels awake after reset");
    a_sleep_clear_wakes: assert property ((ext_wr && !req_in.data[0]
        && req_in.addr[2:0] == chan_sync_pkg::EXT_SLEEP) |=> chan_active_out[0])
        else $error("cleared sleep bit left channel asleep");
    a_soft_start_delay: assert property ((ext_wr && req_in.data[4] && req_in.data[0]
        && req_in.addr[2:0] == chan_sync_pkg::EXT_SOFT_START && start_hold_q == 16'h0002
        && !chan_active_out[0]) |=> !chan_active_out[0] [*8] ##1 chan_active_out[0])
        else $error("soft start wake time wrong");
    a_soft_hop_delay: assert property ((ext_wr && req_in.data[4] && req_in.data[0]
        && req_in.addr[2:0] == chan_sync_pkg::EXT_PIN_HOP && freq_hold_q == 16'h0002)
        |-> ##2 $stable(osc0) [*8] ##1 osc0 == freq_next_q[FREQ_W-1:0])
        else $error("soft hop load time wrong");
    a_direct_freq: assert property ((ch0_wr && freq_hold_q == 16'h0000
        && req_in.addr == chan_sync_pkg::CH_TUNE_FREQ) |=> osc0 == freq_next_q[FREQ_W-1:0])
        else $error("frequency not loaded at once");
    a_shadow_waits: assert property ((ch0_wr && freq_hold_q != 16'h0000
        && req_in.addr == chan_sync_pkg::CH_TUNE_FREQ) |=> $stable(osc0))
        else $error("frequency loaded without release");
endmodule

bind channel_start_hop_sync channel_start_hop_sync_asserts #(
    .NUM_CH(NUM_CH),
    .FREQ_W(FREQ_W)
) i_asserts (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req_in), .sync_pin_in(sync_pin_in),
    .ready_out(ready_out), .rd_data_out(rd_data_out), .chan_active_out(chan_active_out),
    .osc_freq_out(osc_freq_out)
);
`default_nettype wire

/* test/channel_start_hop_sync_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_start_hop_sync_bench;
    logic clock_in;
    logic rst_n_in;
    chan_sync_pkg::reg_req_t req_in;
    logic [3:0] sync_pin_in;
    logic ready_out;
    logic [31:0] rd_data_out;
    logic [3:0] chan_active_out;
    logic [127:0] osc_freq_out;
    logic [31:0] rd_val;
    int err_count;
    int checks;

    channel_start_hop_sync i_dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req_in), .sync_pin_in(sync_pin_in),
        .ready_out(ready_out), .rd_data_out(rd_data_out), .chan_active_out(chan_active_out),
        .osc_freq_out(osc_freq_out)
    );
    host_sync_model i_host (
        .clock_in(clock_in), .rd_data_in(rd_data_out), .req_out(req_in), .pin_out(sync_pin_in)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic wr(input logic ext, input logic [1:0] chan, input logic [7:0] addr,
                      input logic [31:0] data);
        i_host.access(1'h1, ext, chan, addr, data, rd_val);
    endtask

    task automatic edges(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic end_sim;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        wr(1'h0, 2'h0, 8'h83, 32'h00000002);
        chk(32'(ready_out), 32'h1, "no ready after write");
        wr(1'h0, 2'h1, 8'h83, 32'h00000003);
        i_host.access(1'h0, 1'h0, 2'h0, 8'h83, 32'h0, rd_val);
        chk(rd_val, 32'h00000002, "channel 0 hold-off lost");
        i_host.access(1'h0, 1'h0, 2'h0, 8'h90, 32'h0, rd_val);
        chk(rd_val, 32'h00000000, "unmapped read not zero");
    endtask

    task automatic t_direct_freq;
        wr(1'h0, 2'h0, 8'h85, 32'h1234abcd);
        chk(osc_freq_out[31:0], 32'h1234abcd, "direct frequency not loaded");
    endtask

    task automatic t_soft_start;
        wr(1'h1, 2'h0, 8'h05, 32'h00000011);
        edges(7);
        chk(32'(chan_active_out), 32'h0, "soft start too early");
        edges(1);
        chk(32'(chan_active_out), 32'h1, "soft start missing");
    endtask

    task automatic t_pin_start;
        wr(1'h0, 2'h1, 8'h86, 32'h00000001);
        wr(1'h1, 2'h0, 8'h04, 32'h00000222);
        i_host.pulse(0);
        edges(8);
        chk(32'(chan_active_out), 32'h1, "woken by unselected pin");
        i_host.pulse(1);
        edges(5);
        chk(32'(chan_active_out), 32'h1, "pin start too early");
        edges(1);
        chk(32'(chan_active_out), 32'h3, "pin start missing");
    endtask

    task automatic t_soft_hop;
        wr(1'h0, 2'h0, 8'h84, 32'h00000002);
        wr(1'h0, 2'h0, 8'h85, 32'h0badf00d);
        chk(osc_freq_out[31:0], 32'h1234abcd, "shadow leaked early");
        wr(1'h1, 2'h0, 8'h04, 32'h00000011);
        edges(8);
        chk(osc_freq_out[31:0], 32'h1234abcd, "soft hop too early");
        edges(1);
        chk(osc_freq_out[31:0], 32'h0badf00d, "soft hop missing");
    endtask

    task automatic t_pin_hop;
        wr(1'h0, 2'h2, 8'h86, 32'h00000003);
        wr(1'h0, 2'h2, 8'h84, 32'h00000002);
        wr(1'h0, 2'h2, 8'h85, 32'hcafe0002);
        wr(1'h1, 2'h0, 8'h04, 32'h00000844);
        i_host.pulse(3);
        edges(6);
        chk(osc_freq_out[95:64], 32'h00000000, "pin hop too early");
        edges(1);
        chk(osc_freq_out[95:64], 32'hcafe0002, "pin hop missing");
    endtask

    task automatic t_sleep;
        wr(1'h1, 2'h0, 8'h03, 32'h0000000f);
        chk(32'(chan_active_out), 32'h0, "sleep bits ignored");
        wr(1'h0, 2'h3, 8'h83, 32'h00000001);
        wr(1'h1, 2'h0, 8'h03, 32'h00000006);
        chk(32'(chan_active_out), 32'h9, "unsynced start wrong");
        i_host.access(1'h0, 1'h1, 2'h0, 8'h03, 32'h0, rd_val);
        chk(rd_val, 32'h00000006, "sleep bits read back wrong");
    endtask

    // mid-run reset with channels awake and frequencies loaded
    task automatic t_reset;
        rst_n_in = 1'h0;
        edges(2);
        chk(32'(chan_active_out), 32'h0, "awake after mid-run reset");
        chk(osc_freq_out[31:0], 32'h0, "frequency kept over reset");
        rst_n_in = 1'h1;
        edges(1);
        chk(32'(chan_active_out), 32'h0, "awake after reset release");
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial
    begin
        clock_in = 1'h0;
        forever #12.5 clock_in = ~clock_in;
    end

    initial
    begin
        #20000;
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_sim();
    end

    initial
    begin
        err_count = 0;
        checks = 0;
        rst_n_in = 1'h0;
        repeat (4) @(posedge clock_in);
        #1;
        chk(32'(chan_active_out), 32'h0, "awake after reset");
        rst_n_in = 1'h1;
        t_regs();
        t_direct_freq();
        t_soft_start();
        t_pin_start();
        t_soft_hop();
        t_pin_hop();
        t_sleep();
        t_reset();
        end_sim();
    end
endmodule
`default_nettype wire

/* test/host_sync_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_sync_model (
    input wire logic clock_in,
    input wire logic [31:0] rd_data_in,
    output var chan_sync_pkg::reg_req_t req_out,
    output var logic [3:0] pin_out
);
    // ------------------------------------------------------------
    // host port and sync pulse source
    // ------------------------------------------------------------
    // idle bus and low pins from time zero
    initial
    begin
        req_out = '0;
        pin_out = 4'h0;
    end

    // one access, held over the edge that takes it
    task automatic access(input logic wr, input logic ext, input logic [1:0] chan,
                          input logic [7:0] addr, input logic [31:0] data,
                          output logic [31:0] rdata);
        @(posedge clock_in);
        #1;
        req_out.wr = wr;
        req_out.rd = !wr;
        req_out.ext = ext;
        req_out.chan = chan;
        req_out.addr = addr;
        req_out.data = data;
        @(posedge clock_in);
        #1;
        rdata = rd_data_in;
        req_out.wr = 1'h0;
        req_out.rd = 1'h0;
        req_out.data = ~data; // released bus does not keep its value
    endtask

    // one-clock high pulse on a sync pin
    task automatic pulse(input int pin);
        @(posedge clock_in);
        #1;
        pin_out[pin] = 1'h1;
        @(posedge clock_in);
        #1;
        pin_out[pin] = 1'h0;
    endtask
endmodule
`default_nettype wire
